// *** hw/mfs_supervisor.sv ***
// Contract
// - manual-reset fault locks starter, motor freewheels until reset
// - manual-reset fault opens trip relay and aux relay
// - fault code flashes while a fault is latched, until reset or auto restart
// - last five faults kept for external reading
// - manual fault clears on new run rising edge after cause gone
// - no run-edge reset when an input is assigned to any-fault reset
// - control supply lost over 200 ms raises auto control-line fault
// - supply problem at run command raises auto power-supply fault
// - locked-rotor detection only in steady state with bypass engaged
// - phase current at least 5x rated over 0.2 s is locked rotor
// - with auto restart off, auto faults behave as manual faults
// - serial, external, overload, thermal, probe, underload, locked rotor are manual
// - logic input resets only thermal fault or any resettable fault
// - auto restart retries six times at 60 s, then manual trip
`default_nettype none
module mfs_supervisor
#(
	parameter int unsigned CTRL_LOSS_CYC = mfs_pkg::CTRL_LOSS_CYC,
	parameter int unsigned LOCK_CYC = mfs_pkg::LOCK_CYC,
	parameter int unsigned RETRY_CYC = mfs_pkg::RETRY_CYC,
	parameter int unsigned FLASH_CYC = mfs_pkg::FLASH_CYC
)
(
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// operator pins
	input wire logic run_input,
	input wire logic assignable_logic_input,
	input wire logic control_supply_terminals,
	input wire logic supply_problem,
	// configuration
	input wire logic three_wire,
	input wire logic auto_restart_en,
	input wire logic aux_isolating,
	input wire mfs_pkg::mfs_li_t li_assign,
	// motor sensing, same clock domain
	input wire logic steady_state,
	input wire logic bypass_engaged,
	input wire mfs_pkg::mfs_cur_t currents,
	input wire mfs_pkg::mfs_det_t detect,
	// outputs
	output logic lockout,
	output logic freewheel,
	output logic trip_relay_output,
	output logic aux_relay_output,
	output logic [3:0] display_code,
	output logic display_on,
	output logic manual_latched,
	// history read
	input wire logic [2:0] hist_index,
	output logic [3:0] hist_code
);
	typedef enum logic [1:0] {MFS_RUNOK, MFS_AUTO_WAIT, MFS_MANUAL} mfs_st_t;

	logic [2:0] run_s, li_s, cl_s, sp_s;
	logic [2:0] next_run_s, next_li_s, next_cl_s, next_sp_s;
	mfs_st_t st, next_st;
	mfs_pkg::mfs_code_t code, next_code;
	logic [31:0] loss_cnt, next_loss_cnt, lock_cnt, next_lock_cnt;
	logic [31:0] retry_cnt, next_retry_cnt, flash_cnt, next_flash_cnt;
	logic [2:0] tries, next_tries;
	logic flash, next_flash, li_pulse, next_li_pulse;
	logic run_rise, li_rise, cause_present, lock_hit, push;
	mfs_pkg::mfs_code_t new_code;

	function automatic logic over5(input logic [mfs_pkg::CUR_W-1:0] i,
		input logic [mfs_pkg::CUR_W-1:0] r);
		return {3'h0, i} >= 15'(r) * 15'(mfs_pkg::LOCK_MULT);
	endfunction

	// two flip-flop synchronisers; only bit 1 and later are read by logic
	always_comb
	begin
		next_run_s = {run_s[1:0], run_input};
		next_li_s = {li_s[1:0], assignable_logic_input};
		next_cl_s = {cl_s[1:0], control_supply_terminals};
		next_sp_s = {sp_s[1:0], supply_problem};
	end
	assign run_rise = run_s[1] & ~run_s[2];
	assign li_rise = li_s[1] & ~li_s[2];

	assign lock_hit = over5(currents.phase_a, currents.rated) |
		over5(currents.phase_b, currents.rated) |
		over5(currents.phase_c, currents.rated);

	always_comb
	begin
		next_loss_cnt = 32'h0;
		if (!cl_s[2] && loss_cnt <= CTRL_LOSS_CYC)
			next_loss_cnt = loss_cnt + 32'h1;
		else if (!cl_s[2])
			next_loss_cnt = loss_cnt;
		next_lock_cnt = 32'h0;
		if (steady_state && bypass_engaged && lock_hit)
			next_lock_cnt = (lock_cnt <= LOCK_CYC) ? lock_cnt + 32'h1 : lock_cnt;
	end

	always_comb
	begin
		new_code = mfs_pkg::MFS_NONE;
		if (lock_cnt > LOCK_CYC)
			new_code = mfs_pkg::MFS_LOCKED_ROTOR;
		else if (detect.serial_link)
			new_code = mfs_pkg::MFS_SERIAL_LINK;
		else if (detect.external)
			new_code = mfs_pkg::MFS_EXTERNAL;
		else if (detect.cur_overload)
			new_code = mfs_pkg::MFS_CUR_OVERLOAD;
		else if (detect.motor_thermal)
			new_code = mfs_pkg::MFS_MOTOR_THERMAL;
		else if (detect.probe_thermal)
			new_code = mfs_pkg::MFS_PROBE_THERMAL;
		else if (detect.underload)
			new_code = mfs_pkg::MFS_UNDERLOAD;
		else if (loss_cnt > CTRL_LOSS_CYC)
			new_code = mfs_pkg::MFS_CONTROL_LINE;
		else if (sp_s[2] && run_rise)
			new_code = mfs_pkg::MFS_POWER_SUPPLY;
	end

	// latched fault's own cause still active
	always_comb
	begin
		unique case (code)
			mfs_pkg::MFS_CONTROL_LINE: cause_present = !cl_s[2];
			mfs_pkg::MFS_POWER_SUPPLY: cause_present = sp_s[2];
			mfs_pkg::MFS_SERIAL_LINK: cause_present = detect.serial_link;
			mfs_pkg::MFS_EXTERNAL: cause_present = detect.external;
			mfs_pkg::MFS_CUR_OVERLOAD: cause_present = detect.cur_overload;
			mfs_pkg::MFS_MOTOR_THERMAL: cause_present = detect.motor_thermal;
			mfs_pkg::MFS_PROBE_THERMAL: cause_present = detect.probe_thermal;
			mfs_pkg::MFS_UNDERLOAD: cause_present = detect.underload;
			mfs_pkg::MFS_LOCKED_ROTOR: cause_present = lock_hit;
			default: cause_present = 1'b0;
		endcase
	end

	always_comb
	begin
		next_st = st;
		next_code = code;
		next_tries = tries;
		next_retry_cnt = 32'h0;
		next_li_pulse = li_pulse;
		push = 1'b0;
		unique case (st)
			MFS_RUNOK:
				if (new_code != mfs_pkg::MFS_NONE)
				begin
					push = 1'b1;
					next_code = new_code;
					next_tries = 3'h0;
					next_li_pulse = 1'b0;
					if (mfs_pkg::mfs_is_manual(new_code) || !auto_restart_en)
						next_st = MFS_MANUAL;
					else
						next_st = MFS_AUTO_WAIT;
				end
			MFS_AUTO_WAIT:
				if (!auto_restart_en)
					next_st = MFS_MANUAL;
				else if (retry_cnt < RETRY_CYC - 1)
					next_retry_cnt = retry_cnt + 32'h1;
				else if (!cause_present)
				begin
					next_st = MFS_RUNOK;
					next_code = mfs_pkg::MFS_NONE;
				end
				else if (tries == 3'(mfs_pkg::RETRY_MAX - 1))
					next_st = MFS_MANUAL;
				else
					next_tries = tries + 3'h1;
			MFS_MANUAL:
			begin
				// pulse is remembered; reset waits for the run condition
				if (li_rise && (li_assign == mfs_pkg::MFS_LI_ANY ||
					(li_assign == mfs_pkg::MFS_LI_THERMAL &&
					code == mfs_pkg::MFS_MOTOR_THERMAL)))
					next_li_pulse = 1'b1;
				if (!cause_present)
				begin
					if (li_assign == mfs_pkg::MFS_LI_NONE ||
						(li_assign == mfs_pkg::MFS_LI_THERMAL &&
						code != mfs_pkg::MFS_MOTOR_THERMAL))
					begin
						if (run_rise)
						begin
							next_st = MFS_RUNOK;
							next_code = mfs_pkg::MFS_NONE;
						end
					end
					else if (next_li_pulse && (three_wire ? run_rise : run_s[2]))
					begin
						next_st = MFS_RUNOK;
						next_code = mfs_pkg::MFS_NONE;
						next_li_pulse = 1'b0;
					end
				end
			end
		endcase
	end

	always_comb
	begin
		next_flash_cnt = flash_cnt + 32'h1;
		next_flash = flash;
		if (st == MFS_RUNOK)
		begin
			next_flash_cnt = 32'h0;
			next_flash = 1'b1;
		end
		else if (flash_cnt >= FLASH_CYC - 1)
		begin
			next_flash_cnt = 32'h0;
			next_flash = ~flash;
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			run_s <= 3'h0;
			li_s <= 3'h0;
			cl_s <= 3'h7;
			sp_s <= 3'h0;
			st <= MFS_RUNOK;
			code <= mfs_pkg::MFS_NONE;
			loss_cnt <= 32'h0;
			lock_cnt <= 32'h0;
			retry_cnt <= 32'h0;
			flash_cnt <= 32'h0;
			tries <= 3'h0;
			flash <= 1'b1;
			li_pulse <= 1'b0;
			lockout <= 1'b0;
			freewheel <= 1'b0;
			trip_relay_output <= 1'b1;
			aux_relay_output <= 1'b1;
			display_code <= 4'h0;
			display_on <= 1'b0;
			manual_latched <= 1'b0;
		end
		else
		begin
			run_s <= next_run_s;
			li_s <= next_li_s;
			cl_s <= next_cl_s;
			sp_s <= next_sp_s;
			st <= next_st;
			code <= next_code;
			loss_cnt <= next_loss_cnt;
			lock_cnt <= next_lock_cnt;
			retry_cnt <= next_retry_cnt;
			flash_cnt <= next_flash_cnt;
			tries <= next_tries;
			flash <= next_flash;
			li_pulse <= next_li_pulse;
			lockout <= next_st != MFS_RUNOK;
			freewheel <= next_st != MFS_RUNOK;
			trip_relay_output <= next_st == MFS_RUNOK;
			// isolating role opens on any fault; fault role only on manual
			aux_relay_output <= !(next_st == MFS_MANUAL ||
				(next_st == MFS_AUTO_WAIT && aux_isolating));
			display_code <= next_code;
			display_on <= next_st == MFS_RUNOK || next_flash;
			manual_latched <= next_st == MFS_MANUAL;
		end
	end

	mfs_history u_hist
	(
		.clk(clk),
		.rst(rst),
		.push(push),
		.code(new_code),
		.rd_index(hist_index),
		.rd_code(hist_code)
	);

	AST_MANUAL_RELAYS: assert property (@(posedge clk) disable iff (rst)
		st == MFS_MANUAL |-> !trip_relay_output && !aux_relay_output && freewheel)
		else $error("relays not open in manual fault");
	AST_LOCK_ONLY_STEADY: assert property (@(posedge clk) disable iff (rst)
		!(steady_state && bypass_engaged) |=> lock_cnt == 32'h0)
		else $error("locked rotor timing outside steady state");
	AST_CLASS_MANUAL: assert property (@(posedge clk) disable iff (rst)
		st == MFS_RUNOK && new_code != mfs_pkg::MFS_NONE &&
		mfs_pkg::mfs_is_manual(new_code) |=> st == MFS_MANUAL)
		else $error("manual class fault not latched");
	AST_NO_AUTO_WHEN_OFF: assert property (@(posedge clk) disable iff (rst)
		!auto_restart_en && st == MFS_AUTO_WAIT |=> st == MFS_MANUAL)
		else $error("auto fault kept with restart off");
	AST_LIR_BLOCKS_RUN: assert property (@(posedge clk) disable iff (rst)
		st == MFS_MANUAL && li_assign == mfs_pkg::MFS_LI_ANY && !li_pulse && !li_rise
		|=> st == MFS_MANUAL)
		else $error("run edge reset with any-fault input assigned");
	AST_RESET_NEEDS_EDGE: assert property (@(posedge clk) disable iff (rst)
		st == MFS_MANUAL && li_assign == mfs_pkg::MFS_LI_NONE && !run_rise
		|=> st == MFS_MANUAL)
		else $error("manual fault cleared without run edge");
	AST_RETRY_LIMIT: assert property (@(posedge clk) disable iff (rst)
		st == MFS_AUTO_WAIT |-> tries < 3'(mfs_pkg::RETRY_MAX))
		else $error("retry count exceeded");
	AST_CTRL_LOSS: assert property (@(posedge clk) disable iff (rst)
		loss_cnt > CTRL_LOSS_CYC && st == MFS_RUNOK |=> st != MFS_RUNOK)
		else $error("control line loss not raised");
endmodule // mfs_supervisor
`default_nettype wire

// *** hw/mfs_pkg.sv ***
`default_nettype none
package mfs_pkg;
	localparam int unsigned CLK_HZ = 20_000_000;
	localparam int unsigned CTRL_LOSS_MS = 200;
	localparam int unsigned CTRL_LOSS_CYC = CLK_HZ / 1000 * CTRL_LOSS_MS;
	localparam int unsigned LOCK_MS = 200;
	localparam int unsigned LOCK_CYC = CLK_HZ / 1000 * LOCK_MS;
	localparam int unsigned RETRY_S = 60;
	localparam int unsigned RETRY_CYC = CLK_HZ * RETRY_S;
	localparam int unsigned RETRY_MAX = 6;
	localparam int unsigned HIST_DEPTH = 5;
	localparam int unsigned FLASH_CYC = CLK_HZ / 4;
	localparam int unsigned CUR_W = 12;
	localparam int unsigned LOCK_MULT = 5;

	typedef enum logic [3:0] {
		MFS_NONE = 4'h0,
		MFS_POWER_SUPPLY = 4'h1,
		MFS_CONTROL_LINE = 4'h2,
		MFS_SERIAL_LINK = 4'h3,
		MFS_EXTERNAL = 4'h4,
		MFS_CUR_OVERLOAD = 4'h5,
		MFS_MOTOR_THERMAL = 4'h6,
		MFS_PROBE_THERMAL = 4'h7,
		MFS_UNDERLOAD = 4'h8,
		MFS_LOCKED_ROTOR = 4'h9
	} mfs_code_t;

	typedef enum logic [1:0] {
		MFS_LI_NONE = 2'h0,
		MFS_LI_THERMAL = 2'h1,
		MFS_LI_ANY = 2'h2
	} mfs_li_t;

	typedef struct packed {
		logic [CUR_W-1:0] phase_a;
		logic [CUR_W-1:0] phase_b;
		logic [CUR_W-1:0] phase_c;
		logic [CUR_W-1:0] rated;
	} mfs_cur_t;

	typedef struct packed {
		logic serial_link;
		logic external;
		logic cur_overload;
		logic motor_thermal;
		logic probe_thermal;
		logic underload;
	} mfs_det_t;

	function automatic logic mfs_is_manual(input mfs_code_t c);
		return c inside {MFS_SERIAL_LINK, MFS_EXTERNAL, MFS_CUR_OVERLOAD,
			MFS_MOTOR_THERMAL, MFS_PROBE_THERMAL, MFS_UNDERLOAD, MFS_LOCKED_ROTOR};
	endfunction
endpackage
`default_nettype wire

// *** hw/mfs_history.sv ***
`default_nettype none
module mfs_history
(
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// new entry
	input wire logic push,
	input wire mfs_pkg::mfs_code_t code,
	// read side, index 0 is newest
	input wire logic [2:0] rd_index,
	output logic [3:0] rd_code
);
	mfs_pkg::mfs_code_t mem [mfs_pkg::HIST_DEPTH];
	mfs_pkg::mfs_code_t next_mem [mfs_pkg::HIST_DEPTH];
	logic [3:0] next_rd_code;

	always_comb
	begin
		for (int i = 0; i < mfs_pkg::HIST_DEPTH; i++)
			next_mem[i] = mem[i];
		if (push)
		begin
			// oldest entry falls off the end
			for (int i = mfs_pkg::HIST_DEPTH - 1; i > 0; i--)
				next_mem[i] = mem[i-1];
			next_mem[0] = code;
		end
		next_rd_code = 4'h0;
		if (rd_index < 3'(mfs_pkg::HIST_DEPTH))
			next_rd_code = mem[rd_index];
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			for (int i = 0; i < mfs_pkg::HIST_DEPTH; i++)
				mem[i] <= mfs_pkg::MFS_NONE;
			rd_code <= 4'h0;
		end
		else
		begin
			mem <= next_mem;
			rd_code <= next_rd_code;
		end
	end

	AST_HIST_SHIFT: assert property (@(posedge clk) disable iff (rst)
		push |=> mem[0] == $past(code) && mem[1] == $past(mem[0]))
		else $error("history did not shift on push");
endmodule // mfs_history
`default_nettype wire

// *** testbench/mfs_operator.sv ***
`default_nettype none
module mfs_operator
(
	// clock
	input wire logic clk,
	// load setting
	input wire logic [11:0] rated,
	input wire logic [2:0] mult,
	// operator pins and sensing
	output logic run_input,
	output logic assignable_logic_input,
	output var mfs_pkg::mfs_cur_t currents
);
	timeunit 1ns;
	timeprecision 1ns;
	initial
	begin
		run_input = 1'b0;
		assignable_logic_input = 1'b0;
	end
	// only phase b carries the overload, so a single-phase fault is what trips
	always_comb currents = '{phase_a: rated, phase_b: 12'(rated * mult), phase_c: rated, rated: rated};
	task automatic set_run(input logic v);
		@(negedge clk);
		run_input = v;
	endtask
	// pulse is held a few cycles so it survives the pin synchroniser
	task automatic li_pulse();
		@(negedge clk);
		assignable_logic_input = 1'b1;
		repeat (4) @(negedge clk);
		assignable_logic_input = 1'b0;
	endtask
endmodule // mfs_operator
`default_nettype wire

// *** testbench/testbench.sv ***
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk, rst, ctl, sup, three_wire, auto_restart_en, aux_isolating;
	logic steady_state, bypass_engaged, run_input, assignable_logic_input;
	logic lockout, freewheel, trip_relay_output, aux_relay_output, display_on, manual_latched;
	logic [3:0] display_code, hist_code;
	logic [2:0] hist_index, mult;
	logic [11:0] rated;
	logic [31:0] lfsr;
	mfs_pkg::mfs_li_t li_assign;
	mfs_pkg::mfs_cur_t currents;
	mfs_pkg::mfs_det_t detect;
	int bad_count, n_tests, m_code, hi, lo, j, off;
	bit m_man;
	int hist_q[$];
	mfs_supervisor #(.CTRL_LOSS_CYC(20), .LOCK_CYC(10), .RETRY_CYC(50), .FLASH_CYC(4))
		mfs_supervisor_i (.clk, .rst, .run_input, .assignable_logic_input,
		.control_supply_terminals(ctl), .supply_problem(sup), .three_wire, .auto_restart_en,
		.aux_isolating, .li_assign, .steady_state, .bypass_engaged, .currents, .detect,
		.lockout, .freewheel, .trip_relay_output, .aux_relay_output, .display_code,
		.display_on, .manual_latched, .hist_index, .hist_code);
	mfs_operator mfs_operator_i (.clk, .rated, .mult, .run_input, .assignable_logic_input,
		.currents);
	initial
	begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	function automatic logic [31:0] lfsr_next(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [3:0] e, input logic [3:0] g);
		n_tests++;
		if (g !== e)
		begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask
	// outputs predicted from the model state and the aux_isolating setting
	task automatic chk_out();
		chk("lockout", {3'h0, m_code != 0}, {3'h0, lockout});
		chk("freewheel", {3'h0, m_code != 0}, {3'h0, freewheel});
		chk("trip", {3'h0, m_code == 0}, {3'h0, trip_relay_output});
		chk("aux", {3'h0, !(m_man || (m_code != 0 && aux_isolating))}, {3'h0, aux_relay_output});
		chk("code", 4'(m_code), display_code);
		chk("manual", {3'h0, m_man}, {3'h0, manual_latched});
		if (m_code == 0)
			chk("display_on", 4'h1, {3'h0, display_on});
	endtask
	task automatic fault(input int c, input bit man);
		m_code = c;
		m_man = man;
		hist_q.push_front(c);
		if (hist_q.size() > 5)
			void'(hist_q.pop_back());
	endtask
	task automatic run_clear();
		mfs_operator_i.set_run(1'b1);
		cyc(6);
		m_code = 0;
		m_man = 0;
		chk_out();
		mfs_operator_i.set_run(1'b0);
	endtask
	initial
	begin
		repeat (3000) @(posedge clk);
		bad_count++;
		end_sim();
	end
	initial
	begin
		{rst, ctl, sup, three_wire, auto_restart_en, aux_isolating} = 6'h31;
		{steady_state, bypass_engaged, mult, hist_index, detect} = '0;
		li_assign = mfs_pkg::MFS_LI_NONE;
		rated = 12'h064;
		lfsr = 32'h18d58164;
		repeat (8) @(posedge clk);
		@(negedge clk);
		rst = 1'b0;
		cyc(4);
		// one random rotation keeps all six detector fault codes in the sweep; locked rotor is tested later
		lfsr = lfsr_next(lfsr);
		off = int'(lfsr[10:8]);
		for (int i = 0; i < 6; i++)
		begin
			lfsr = lfsr_next(lfsr);
			j = (i + off) % 6;
			{aux_isolating, three_wire, auto_restart_en, steady_state, bypass_engaged} = lfsr[4:0];
			// thermal-only assignment leaves run-edge reset in force for other faults
			li_assign = (j != 3 && lfsr[5]) ? mfs_pkg::MFS_LI_THERMAL : mfs_pkg::MFS_LI_NONE;
			detect = 6'(6'h20 >> j);
			cyc(4);
			fault(3 + j, 1);
			chk_out();
			mfs_operator_i.set_run(1'b1);
			cyc(6);
			chk_out();
			{hi, lo} = '0;
			repeat (12) @(negedge clk)
				if (display_on === 1'b1)
					hi++;
				else if (display_on === 1'b0)
					lo++;
			chk("flash", 4'h1, {3'h0, hi > 0 && lo > 0});
			mfs_operator_i.set_run(1'b0);
			detect = '0;
			run_clear();
		end
		$display("test manual faults done");
		{three_wire, auto_restart_en, steady_state, bypass_engaged} = '0;
		li_assign = mfs_pkg::MFS_LI_ANY;
		detect = 6'h10;
		cyc(4);
		fault(4, 1);
		detect = '0;
		mfs_operator_i.set_run(1'b1);
		cyc(6);
		chk_out();
		mfs_operator_i.li_pulse();
		cyc(6);
		m_code = 0;
		m_man = 0;
		chk_out();
		mfs_operator_i.set_run(1'b0);
		three_wire = 1'b1;
		detect = 6'h01;
		cyc(4);
		fault(8, 1);
		detect = '0;
		mfs_operator_i.li_pulse();
		cyc(6);
		chk_out();
		run_clear();
		{three_wire, li_assign} = '0;
		$display("test logic input reset done");
		sup = 1'b1;
		cyc(4);
		mfs_operator_i.set_run(1'b1);
		cyc(6);
		fault(1, 1);
		chk_out();
		sup = 1'b0;
		mfs_operator_i.set_run(1'b0);
		run_clear();
		$display("test supply fault done");
		auto_restart_en = 1'b1;
		for (int k = 0; k < 2; k++)
		begin
			lfsr = lfsr_next(lfsr);
			aux_isolating = lfsr[0];
			ctl = 1'b0;
			cyc(15);
			chk_out();
			cyc(15);
			fault(2, 0);
			chk_out();
			if (k == 0)
			begin
				ctl = 1'b1;
				cyc(60);
				m_code = 0;
				chk_out();
			end
		end
		cyc(100);
		chk_out();
		cyc(250);
		m_man = 1;
		chk_out();
		ctl = 1'b1;
		run_clear();
		$display("test control line done");
		lfsr = lfsr_next(lfsr);
		rated = 12'(50 + lfsr[7:0]);
		mult = lfsr[8] ? 3'h7 : 3'h5;
		bypass_engaged = 1'b1;
		cyc(20);
		chk_out();
		steady_state = 1'b1;
		cyc(8);
		chk_out();
		cyc(8);
		fault(9, 1);
		chk_out();
		{mult, steady_state} = {3'h1, 1'b0};
		run_clear();
		$display("test locked rotor done");
		for (int i = 0; i < 8; i++)
		begin
			hist_index = 3'(i);
			cyc(2);
			chk("hist", (i < hist_q.size()) ? 4'(hist_q[i]) : 4'h0, hist_code);
		end
		$display("test history done");
		end_sim();
	end
endmodule // testbench
`default_nettype wire
